// *** src/eag_pkg.sv ***
// Package for the effective address generator: modes, lengths, carriers
`default_nettype none
package eag_pkg;
    // Addressing modes decoded by the sequencer
    typedef enum logic [3:0] {
        EAG_INH, EAG_IMM, EAG_DIR, EAG_EXT, EAG_IX0, EAG_IX1, EAG_IX2,
        EAG_REL, EAG_BSC, EAG_BTB
    } eag_mode_t;

    // Instruction lengths in bytes
    localparam logic [15:0] EAG_LEN_ONE = 16'h0001;
    localparam logic [15:0] EAG_LEN_TWO = 16'h0002;
    localparam logic [15:0] EAG_LEN_THREE = 16'h0003;
    // Opcode field positions for bit modes
    localparam int EAG_BITNUM_LSB = 1;
    localparam int EAG_POL_BIT = 0;
    localparam logic [7:0] EAG_ZERO_PAGE = 8'h00;

    // Request from the sequencer
    typedef struct packed {
        eag_mode_t mode;
        logic [7:0] opcode;
        logic [15:0] pc;
        logic [7:0] index;
        logic branch_cond;
    } eag_req_t;

    // Result held until the next request
    typedef struct packed {
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [15:0] next_pc;
        logic [15:0] pc_inc;
        logic uses_ea;
        logic carry_valid;
        logic carry_val;
        logic [2:0] bit_num;
    } eag_res_t;
endpackage
`default_nettype wire

// *** src/eag_core.sv ***
// Effective address and next program counter generation
// How it works
// - Inherent: no operand fetch, one byte
// - Immediate: operand at PC+1, PC+2
// - Direct: high zero, low operand, PC+2
// - Extended: first byte high, second low, PC+3
// - Indexed none: X on low, PC+1
// - Indexed byte: X plus byte, carry high
// - Indexed word: carry into first byte high
// - Relative: add signed offset only if taken
// - Relative span -126 to +129 from opcode
// - Bit set/clear: page-zero address, PC+2
// - Bit branch: PC+3 plus offset if met
// - Bit branch span -125 to +130
// - Tested bit always copied to carry
`default_nettype none
module eag_core
    import eag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input var eag_req_t req,
    output logic req_ready,
    output logic fetch_req,
    output logic [15:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_data,
    output logic res_valid,
    output var eag_res_t res
);
    typedef enum {ST_IDLE, ST_FETCH, ST_TEST, ST_DONE} eag_state_t;
    eag_state_t state_reg;
    eag_req_t req_reg;
    logic [1:0] need_reg, got_reg;
    logic [7:0] op1_reg, op2_reg;

    // Operand bytes each mode needs from the stream, bit branch counted as one
    function automatic logic [1:0] eag_operands(input eag_mode_t m);
        unique case (m)
            EAG_INH, EAG_IX0: eag_operands = 2'd0;
            EAG_EXT, EAG_IX2: eag_operands = 2'd2;
            default: eag_operands = 2'd1;
        endcase
    endfunction

    // Sign extend an 8-bit branch offset
    function automatic logic [15:0] eag_sext(input logic [7:0] v);
        eag_sext = {{8{v[7]}}, v};
    endfunction

    assign req_ready = (state_reg == ST_IDLE);
    assign fetch_req = (state_reg == ST_FETCH);
    // Fetch pointer kept in flip-flops so the address pins never glitch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_addr <= 16'h0000;
        end else if (state_reg == ST_IDLE && req_valid) begin
            fetch_addr <= req.pc + 16'h0001;
        end else if (state_reg == ST_FETCH && fetch_valid) begin
            fetch_addr <= fetch_addr + 16'h0001; // Ascending, one byte per answer
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch operands, then test byte for bit branch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            need_reg <= 2'd0;
            got_reg <= 2'd0;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (req_valid) begin
                    req_reg <= req;
                    need_reg <= eag_operands(req.mode);
                    got_reg <= 2'd0;
                    // Bit branch needs its offset too: three bytes total
                    if (req.mode == EAG_BTB) need_reg <= 2'd2;
                    state_reg <= (eag_operands(req.mode) == 2'd0) ? ST_DONE : ST_FETCH;
                end
                ST_FETCH: if (fetch_valid) begin
                    got_reg <= got_reg + 2'd1;
                    if (got_reg + 2'd1 == need_reg)
                        state_reg <= (req_reg.mode == EAG_BTB) ? ST_TEST : ST_DONE;
                end
                ST_TEST: if (fetch_valid) state_reg <= ST_DONE;
                ST_DONE: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Operand capture in ascending order
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            op1_reg <= 8'h00;
            op2_reg <= 8'h00;
        end else if (state_reg == ST_FETCH && fetch_valid) begin
            if (got_reg == 2'd0) op1_reg <= fetch_data;
            else op2_reg <= fetch_data;
        end
    end

    // Tested bit captured from the zero-page byte
    logic tbit_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) tbit_reg <= 1'b0;
        else if (state_reg == ST_TEST && fetch_valid)
            tbit_reg <= fetch_data[req_reg.opcode[EAG_BITNUM_LSB +: 3]];
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and next PC computation
    eag_res_t calc;
    logic [8:0] xsum1, xsum2;
    logic [15:0] seq_pc, tgt_pc;
    logic met;
    always_comb begin
        calc = '0;
        xsum1 = {1'b0, req_reg.index} + {1'b0, op1_reg};
        xsum2 = {1'b0, req_reg.index} + {1'b0, op2_reg};
        seq_pc = 16'h0000;
        tgt_pc = 16'h0000;
        met = 1'b0;
        calc.bit_num = req_reg.opcode[EAG_BITNUM_LSB +: 3];
        unique case (req_reg.mode)
            EAG_INH: calc.pc_inc = EAG_LEN_ONE;
            EAG_IMM: begin
                {calc.addr_hi, calc.addr_lo} = req_reg.pc + 16'h0001;
                calc.pc_inc = EAG_LEN_TWO;
                calc.uses_ea = 1'b1;
            end
            EAG_DIR, EAG_BSC: begin
                calc.addr_hi = EAG_ZERO_PAGE;
                calc.addr_lo = op1_reg;
                calc.pc_inc = EAG_LEN_TWO;
                calc.uses_ea = 1'b1;
            end
            EAG_EXT: begin
                calc.addr_hi = op1_reg;
                calc.addr_lo = op2_reg;
                calc.pc_inc = EAG_LEN_THREE;
                calc.uses_ea = 1'b1;
            end
            EAG_IX0: begin
                calc.addr_hi = EAG_ZERO_PAGE;
                calc.addr_lo = req_reg.index;
                calc.pc_inc = EAG_LEN_ONE;
                calc.uses_ea = 1'b1;
            end
            EAG_IX1: begin
                calc.addr_hi = {7'h00, xsum1[8]};
                calc.addr_lo = xsum1[7:0];
                calc.pc_inc = EAG_LEN_TWO;
                calc.uses_ea = 1'b1;
            end
            EAG_IX2: begin
                calc.addr_hi = op1_reg + {7'h00, xsum2[8]};
                calc.addr_lo = xsum2[7:0];
                calc.pc_inc = EAG_LEN_THREE;
                calc.uses_ea = 1'b1;
            end
            EAG_REL: begin
                seq_pc = req_reg.pc + EAG_LEN_TWO;
                tgt_pc = seq_pc + eag_sext(op1_reg);
                met = req_reg.branch_cond;
                calc.pc_inc = EAG_LEN_TWO;
            end
            EAG_BTB: begin
                calc.addr_hi = EAG_ZERO_PAGE;
                calc.addr_lo = op1_reg;
                calc.uses_ea = 1'b1;
                seq_pc = req_reg.pc + EAG_LEN_THREE;
                tgt_pc = seq_pc + eag_sext(op2_reg);
                // Polarity bit low means branch when set
                met = tbit_reg ^ req_reg.opcode[EAG_POL_BIT];
                calc.pc_inc = EAG_LEN_THREE;
                calc.carry_valid = 1'b1;
                calc.carry_val = tbit_reg;
            end
        endcase
        if (req_reg.mode == EAG_REL || req_reg.mode == EAG_BTB)
            calc.next_pc = met ? tgt_pc : seq_pc;
        else
            calc.next_pc = req_reg.pc + calc.pc_inc;
    end

    // Result registered; it stands until the next request completes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            res <= '0;
            res_valid <= 1'b0;
        end else begin
            res_valid <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE) res <= calc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ext_addr;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_EXT) |->
            {res.addr_hi, res.addr_lo} == {op1_reg, op2_reg};
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");
    property p_dir_hi;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && (req_reg.mode == EAG_DIR || req_reg.mode == EAG_IX0)) |->
            res.addr_hi == 8'h00;
    endproperty
    a_dir_hi: assert property (p_dir_hi) else $error("page zero high byte nonzero");
    property p_ix1;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_IX1) |->
            {res.addr_hi, res.addr_lo} == 16'(req_reg.index) + 16'(op1_reg);
    endproperty
    a_ix1: assert property (p_ix1) else $error("indexed byte sum wrong");
    property p_inc;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_INH) |-> res.next_pc == req_reg.pc + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("inherent length wrong");
    property p_rel;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_REL && !req_reg.branch_cond) |->
            res.next_pc == req_reg.pc + 16'h0002;
    endproperty
    a_rel: assert property (p_rel) else $error("untaken branch moved");
    property p_carry;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_BTB) |-> res.carry_valid && res.carry_val == tbit_reg;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not copied");
    property p_order;
        @(posedge core_clk) disable iff (!rst_b)
        (fetch_req && fetch_valid && got_reg == 2'd0) |=> ##[1:1000] res_valid;
    endproperty
    a_order: assert property (p_order) else $error("result never follows fetch");
    property p_fetch_addr;
        @(posedge core_clk) disable iff (!rst_b)
        fetch_req |-> fetch_addr == req_reg.pc + 16'(got_reg) + 16'h0001;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch out of order");
    // No result may be formed before every operand byte is in
    property p_fetch_done;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == ST_DONE) |-> got_reg == need_reg;
    endproperty
    a_fetch_done: assert property (p_fetch_done) else $error("result before operands");
    property p_btb_pc;
        @(posedge core_clk) disable iff (!rst_b)
        (res_valid && req_reg.mode == EAG_BTB && res.carry_val == req_reg.opcode[0]) |->
            res.next_pc == req_reg.pc + 16'h0003;
    endproperty
    a_btb_pc: assert property (p_btb_pc) else $error("bit branch fallthrough wrong");
    c_ext: cover property (@(posedge core_clk) res_valid && req_reg.mode == EAG_EXT);
    c_rel: cover property (@(posedge core_clk) res_valid && req_reg.mode == EAG_REL);
    c_btb: cover property (@(posedge core_clk) res_valid && req_reg.mode == EAG_BTB);
endmodule
`default_nettype wire

// *** tb/eag_mem_model.sv ***
// Far-side memory model answering operand and tested-byte fetches
`default_nettype none
module eag_mem_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic btb,
    input wire logic [15:0] pc,
    input wire logic [7:0] op1,
    input wire logic [7:0] op2,
    input wire logic [7:0] tbyte,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_valid,
    output logic [7:0] fetch_data,
    output logic order_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_n;
    logic seen1;
    logic second;
    logic want;
    // Test byte is wanted once both operands of a bit branch are in
    assign want = fetch_req || (btb && second);
    // Answer at the falling edge after a random stall of up to two cycles
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_valid <= 1'b0;
            fetch_data <= 8'h00;
            order_err <= 1'b0;
            wait_n <= 2'h0;
            seen1 <= 1'b0;
            second <= 1'b0;
        end else if (fetch_valid) begin
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data; // Released bus never keeps the old byte
        end else if (want && wait_n != 2'h0) begin
            wait_n <= wait_n - 2'h1;
        end else if (want) begin
            fetch_valid <= 1'b1;
            wait_n <= 2'($urandom_range(2, 0));
            if (!fetch_req) begin
                fetch_data <= tbyte;
                second <= 1'b0;
            end else if (fetch_addr == pc + 16'h0001) begin
                fetch_data <= op1;
                seen1 <= 1'b1;
            end else begin
                fetch_data <= op2;
                second <= btb;
                seen1 <= 1'b0;
                // Second byte only at pc+2 and only after the first
                order_err <= order_err | !seen1 | (fetch_addr != pc + 16'h0002);
            end
        end else begin
            seen1 <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/effective_address_generator_bench.sv ***
// Self-checking bench for the effective address generator
`default_nettype none
module effective_address_generator_bench;
    import eag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, req_valid, req_ready, fetch_req, fetch_valid, res_valid, order_err;
    logic [15:0] fetch_addr;
    logic [7:0] fetch_data, op1, op2, tbyte;
    eag_req_t req;
    eag_res_t res;
    int n_errors;
    int total_checks;
    eag_core uut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data), .res_valid(res_valid), .res(res));
    eag_mem_model mem (.core_clk(core_clk), .rst_b(rst_b), .btb(req.mode == EAG_BTB),
        .pc(req.pc), .op1(op1), .op2(op2), .tbyte(tbyte), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .order_err(order_err));
    ////////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Sign-extended branch offsets; bit branch polarity from opcode bit 0
    function automatic logic [15:0] exp_next(eag_req_t r, logic [7:0] a, logic [7:0] b,
            logic [7:0] t);
        case (r.mode)
            EAG_INH, EAG_IX0: return r.pc + 16'h0001;
            EAG_EXT, EAG_IX2: return r.pc + 16'h0003;
            EAG_REL: return r.pc + 16'h0002 + (r.branch_cond ? {{8{a[7]}}, a} : 16'h0000);
            EAG_BTB: return r.pc + 16'h0003 +
                ((t[r.opcode[3:1]] ^ r.opcode[0]) ? {{8{b[7]}}, b} : 16'h0000);
            default: return r.pc + 16'h0002;
        endcase
    endfunction
    function automatic logic [15:0] exp_addr(eag_req_t r, logic [7:0] a, logic [7:0] b);
        case (r.mode)
            EAG_IMM: return r.pc + 16'h0001;
            EAG_EXT: return {a, b};
            EAG_IX0: return {8'h00, r.index};
            EAG_IX1: return {8'h00, r.index} + {8'h00, a};
            EAG_IX2: return {a, 8'h00} + {8'h00, r.index} + {8'h00, b};
            default: return {8'h00, a};
        endcase
    endfunction
    // Instruction length by mode
    function automatic logic [15:0] exp_len(eag_mode_t m);
        case (m)
            EAG_INH, EAG_IX0: return EAG_LEN_ONE;
            EAG_EXT, EAG_IX2, EAG_BTB: return EAG_LEN_THREE;
            default: return EAG_LEN_TWO;
        endcase
    endfunction
    // Entered at a falling edge; holds the request fields until the result
    task automatic run(input eag_req_t r, input logic [7:0] a, input logic [7:0] b,
            input logic [7:0] t);
        int n;
        logic [2:0] bn;
        bn = r.opcode[3:1];
        chk({15'h0000, req_ready}, 16'h0001);
        req = r;
        op1 = a;
        op2 = b;
        tbyte = t;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (res_valid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0000, res_valid}, 16'h0001);
        chk(res.next_pc, exp_next(r, a, b, t));
        chk(res.pc_inc, exp_len(r.mode));
        chk(16'(res.uses_ea), 16'(r.mode != EAG_INH && r.mode != EAG_REL));
        if (r.mode != EAG_INH && r.mode != EAG_REL)
            chk({res.addr_hi, res.addr_lo}, exp_addr(r, a, b));
        if (r.mode inside {EAG_BSC, EAG_BTB})
            chk(16'(res.bit_num), 16'(bn));
        if (r.mode == EAG_BTB)
            chk(16'({res.carry_valid, res.carry_val}), 16'({1'b1, t[bn]}));
        chk({15'h0000, order_err}, 16'h0000);
    endtask
    function automatic eag_req_t mk(eag_mode_t m, logic [7:0] op, logic [15:0] pc,
            logic [7:0] x, logic c);
        return '{mode: m, opcode: op, pc: pc, index: x, branch_cond: c};
    endfunction
    // Stall-prone memory makes the run about 30 us; the limit leaves wide margin
    initial begin
        #500us;
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        finish_test();
    end
    // Reset, corner cases, then back-to-back random requests
    initial begin
        eag_req_t r;
        logic [3:0] m;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        op1 = 8'h00;
        op2 = 8'h00;
        tbyte = 8'h00;
        n_errors = 0;
        total_checks = 0;
        void'($urandom(94414));
        repeat (8) @(negedge core_clk);
        chk({14'h0000, req_ready, res_valid}, 16'h0002);
        rst_b = 1'b1;
        run(mk(EAG_IX1, 8'hE0, 16'h1234, 8'hFF, 1'b0), 8'hFF, 8'h00, 8'h00);
        run(mk(EAG_IX2, 8'hD0, 16'h2000, 8'hFF, 1'b0), 8'hFF, 8'h01, 8'h00);
        run(mk(EAG_REL, 8'h20, 16'h0001, 8'h00, 1'b1), 8'h80, 8'h00, 8'h00);
        run(mk(EAG_REL, 8'h20, 16'h1000, 8'h00, 1'b1), 8'h7F, 8'h00, 8'h00);
        run(mk(EAG_REL, 8'h21, 16'h1000, 8'h00, 1'b0), 8'h7F, 8'h00, 8'h00);
        run(mk(EAG_BTB, 8'h0E, 16'h3000, 8'h00, 1'b0), 8'h40, 8'h80, 8'h80);
        run(mk(EAG_BTB, 8'h0F, 16'h3000, 8'h00, 1'b0), 8'h40, 8'h80, 8'h80);
        run(mk(EAG_BTB, 8'h01, 16'h3000, 8'h00, 1'b0), 8'h41, 8'h7F, 8'hFE);
        run(mk(EAG_EXT, 8'hC6, 16'hFFFE, 8'h00, 1'b0), 8'hAB, 8'hCD, 8'h00);
        $display("test corner done");
        for (int i = 0; i < 300; i++) begin
            m = 4'(i < 10 ? i : $urandom_range(9, 0));
            r = mk(eag_mode_t'(m), 8'($urandom), 16'($urandom), 8'($urandom), 1'($urandom));
            run(r, 8'($urandom), 8'($urandom), 8'($urandom));
        end
        $display("test random done");
        finish_test();
    end
endmodule
`default_nettype wire
